// >>> sts_partner.sv
// Alarm contact and status report receiver model.
// Assumes alarm and report are registered on clock.
`timescale 1ns/100ps
`default_nettype none
module sts_partner (
    input wire logic clock, // System clock.
    input wire logic reset_n, // Reset, active low.
    input wire logic alarm, // Contact drive.
    input wire logic report, // Report request.
    output var int n_reports, // Reports sent.
    output var int pulse_len // Last closure, cycles.
);
    int run;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            n_reports <= 0;
            pulse_len <= 0;
            run <= 0;
        end else begin
            if (report) n_reports <= n_reports + 1;
            if (alarm) run <= run + 1;
            else if (run != 0) begin
                pulse_len <= run;
                run <= 0;
            end
        end
    end
endmodule : sts_partner
`default_nettype wire

// >>> sts_pkg.sv
// Package for the self-test supervisor: timing constants, limits and carriers.
// Assumes a 125 MHz system clock.
package sts_pkg;
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned PULSE_MS = 1000;
    localparam int unsigned PULSE_CYC = (CLK_HZ / 1000) * PULSE_MS;
    localparam int unsigned CNT_W = 28;
    localparam int unsigned RETEST_S = 120;
    localparam int unsigned CONV_NS = 20000;
    localparam int unsigned CONV_CYC = CONV_NS / 8;
    localparam logic [11:0] OFS_WARN_MV = 12'd50;
    localparam logic [11:0] OFS_FAIL_MV = 12'd75;
    localparam logic [11:0] P5_WARN_MV = 12'd300;
    localparam logic [11:0] P5_FAIL_MV = 12'd400;
    localparam logic [11:0] P15_WARN_MV = 12'd800;
    localparam logic [11:0] P15_FAIL_MV = 12'd1200;

    // One bit per test, in this order.
    typedef struct packed {
        logic ram;
        logic rom;
        logic set;
        logic adc;
        logic p5;
        logic p15;
        logic chan;
        logic master_offset_check;
    } sts_tests_t;

    typedef struct packed {
        logic prot_dis;
        logic ctrl_dis;
        logic alarm;
    } sts_act_t;

    typedef enum logic [1:0] {
        ADC_IDLE = 2'b00,
        ADC_BUSY = 2'b01
    } sts_adc_t;

    typedef struct packed {
        sts_tests_t warn;
        sts_tests_t fail;
        sts_act_t act;
        logic report;
        sts_adc_t adc_st;
        logic [CNT_W-1:0] conv_cnt;
        logic [CNT_W-1:0] pulse_cnt;
        logic [CNT_W-1:0] tick_cnt;
        logic [7:0] sec_cnt;
        logic run_all;
        logic [3:0] sock;
        logic ground_pick;
    } sts_state_t;
endpackage : sts_pkg

// >>> sts_supervisor.sv
// Self-test supervisor: gathers test results and drives disables, alarm and reports.
// Assumes test engines present results synchronous to clock.
`timescale 1ns/100ps
`default_nettype none
module sts_supervisor
    import sts_pkg::*;
#(
    parameter int unsigned PULSE_CYCLES = PULSE_CYC,
    parameter int unsigned SEC_CYCLES = CLK_HZ,
    parameter int unsigned RETEST_SECS = RETEST_S,
    parameter int unsigned CONV_LIMIT = CONV_CYC
) (
    input wire logic clock,             // System clock.
    input wire logic reset_n,           // Asynchronous reset, active low.
    input wire logic settings_new,      // Pulse: new settings about to be enabled.
    input wire logic rom_done,          // Pulse: ROM checksum result valid.
    input wire logic [15:0] rom_sum,    // Computed checksum.
    input wire logic [15:0] rom_stored, // Stored checksum.
    input wire logic [3:0] rom_socket,  // Socket of checked ROM.
    input wire logic ram_done,          // Pulse: RAM test result valid.
    input wire logic ram_bad,           // RAM byte failed write/read.
    input wire logic [3:0] ram_socket,  // Socket of checked RAM.
    input wire logic adc_start,         // Pulse: conversion started.
    input wire logic adc_end,           // Pulse: conversion finished.
    input wire logic master_offset_check_done, // Pulse: master offset sample valid.
    input wire logic [11:0] master_offset_check_mv, // Grounded-input offset magnitude, mV.
    input wire logic chan_done,         // Pulse: channel offsets valid.
    input wire logic [11:0] chan_mv,    // Largest channel offset, mV.
    input wire logic set_done,          // Pulse: settings copies compared.
    input wire logic set_differ,        // Settings copies disagree.
    input wire logic sup_done,          // Pulse: supply deviations valid.
    input wire logic [11:0] p5_mv,      // +5 V deviation magnitude, mV.
    input wire logic [11:0] p15_mv,     // Worst 15 V deviation magnitude, mV.
    output logic run_tests,             // Pulse: start all tests.
    output logic master_offset_check_ground, // Selects grounded input for sampling.
    output logic prot_disable,          // Protection disabled.
    output logic ctrl_disable,          // Control disabled.
    output logic alarm,                 // Alarm contact drive.
    output logic report,                // Pulse: send status report.
    output logic [7:0] fail_flags,      // Failing tests.
    output logic [7:0] warn_flags,      // Warning tests.
    output logic [3:0] bad_socket       // Socket named in the report.
);
    sts_state_t q, d;
    logic p5_f, p15_f, any_pulse;

    always_comb begin
        d = q;
        d.report = 1'b0;
        d.run_all = 1'b0;
        any_pulse = 1'b0;
        p5_f = p5_mv > P5_FAIL_MV;
        p15_f = p15_mv > P15_FAIL_MV;
        if (q.tick_cnt >= CNT_W'(SEC_CYCLES - 1)) begin
            d.tick_cnt = '0;
            if (q.sec_cnt >= 8'(RETEST_SECS - 1)) begin
                d.sec_cnt = '0;
                d.run_all = 1'b1;
            end else begin
                d.sec_cnt = q.sec_cnt + 8'h01;
            end
        end else begin
            d.tick_cnt = q.tick_cnt + CNT_W'(1);
        end
        if (settings_new) begin
            d.run_all = 1'b1;
        end
        if (rom_done) begin
            d.fail.rom = rom_sum != rom_stored;
            if (rom_sum != rom_stored) begin
                d.sock = rom_socket;
            end
        end
        if (ram_done) begin
            d.fail.ram = ram_bad;
            if (ram_bad) begin
                d.sock = ram_socket;
            end
        end
        // A finish seen while idle is ignored; only a conversion that ends in time clears.
        case (q.adc_st)
            ADC_IDLE: begin
                if (adc_start) begin
                    d.adc_st = ADC_BUSY;
                    d.conv_cnt = '0;
                end
            end
            ADC_BUSY: begin
                if (adc_end) begin
                    d.adc_st = ADC_IDLE;
                    d.fail.adc = 1'b0;
                end else if (q.conv_cnt >= CNT_W'(CONV_LIMIT)) begin
                    d.adc_st = ADC_IDLE;
                    d.fail.adc = 1'b1;
                end else begin
                    d.conv_cnt = q.conv_cnt + CNT_W'(1);
                end
            end
            default: d.adc_st = ADC_IDLE;
        endcase
        if (master_offset_check_done) begin
            d.fail.master_offset_check = master_offset_check_mv > OFS_FAIL_MV;
            d.warn.master_offset_check = (master_offset_check_mv > OFS_WARN_MV)
                                       && !(master_offset_check_mv > OFS_FAIL_MV);
            if ((master_offset_check_mv > OFS_FAIL_MV) && !q.fail.master_offset_check) begin
                any_pulse = 1'b1;
            end
        end
        // The grounded input stays selected from each test run until its offset sample
        // has been taken; a run in the same cycle as a sample selects it again.
        if (master_offset_check_done) begin
            d.ground_pick = 1'b0;
        end
        if (d.run_all) begin
            d.ground_pick = 1'b1;
        end
        if (chan_done) begin
            d.fail.chan = chan_mv > OFS_FAIL_MV;
            d.warn.chan = (chan_mv > OFS_WARN_MV) && !(chan_mv > OFS_FAIL_MV);
            if ((chan_mv > OFS_FAIL_MV) && !q.fail.chan) begin
                any_pulse = 1'b1;
            end
        end
        if (set_done) begin
            d.fail.set = set_differ;
        end
        if (sup_done) begin
            d.fail.p5 = p5_f;
            d.warn.p5 = (p5_mv > P5_WARN_MV) && !p5_f;
            d.fail.p15 = p15_f;
            d.warn.p15 = (p15_mv > P15_WARN_MV) && !p15_f;
        end
        if (any_pulse) begin
            d.pulse_cnt = CNT_W'(PULSE_CYCLES);
        end else if (q.pulse_cnt != '0) begin
            d.pulse_cnt = q.pulse_cnt - CNT_W'(1);
        end
        d.act.prot_dis = d.fail.ram | d.fail.rom | d.fail.set | d.fail.adc
                       | d.fail.p5 | d.fail.p15;
        d.act.ctrl_dis = d.fail.ram | d.fail.rom | d.fail.set | d.fail.p5;
        d.act.alarm = d.fail.ram | d.fail.rom | d.fail.set | d.fail.adc
                    | d.fail.p5 | d.fail.p15 | (d.pulse_cnt != '0);
        if ((d.fail != q.fail) || (d.warn != q.warn)) begin
            d.report = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            q <= '{warn: '0, fail: '0, act: '0, report: 1'b0, adc_st: ADC_IDLE,
                   conv_cnt: '0, pulse_cnt: '0, tick_cnt: '0, sec_cnt: '0,
                   run_all: 1'b1, sock: 4'h0, ground_pick: 1'b1};
        end else begin
            q <= d;
        end
    end

    assign run_tests = q.run_all;
    assign master_offset_check_ground = q.ground_pick;
    assign prot_disable = q.act.prot_dis;
    assign ctrl_disable = q.act.ctrl_dis;
    assign alarm = q.act.alarm;
    assign report = q.report;
    assign fail_flags = q.fail;
    assign warn_flags = q.warn;
    assign bad_socket = q.sock;

    a_rom_disables: assert property (@(posedge clock) disable iff (!reset_n)
        rom_done && (rom_sum != rom_stored) |=> prot_disable && ctrl_disable && alarm)
        else $error("rom failure not acted on");
    a_adc_timeout: assert property (@(posedge clock) disable iff (!reset_n)
        q.adc_st == ADC_BUSY && !adc_end && q.conv_cnt >= CNT_W'(CONV_LIMIT)
        |=> fail_flags[4]) else $error("adc timeout missed");
    a_adc_ctrl_kept: assert property (@(posedge clock) disable iff (!reset_n)
        fail_flags == 8'h10 |-> prot_disable && !ctrl_disable && alarm)
        else $error("adc failure actions wrong");
    a_offset_levels: assert property (@(posedge clock) disable iff (!reset_n)
        master_offset_check_done && master_offset_check_mv > OFS_WARN_MV
        && master_offset_check_mv <= OFS_FAIL_MV |=> warn_flags[0])
        else $error("offset warning missed");
    a_offset_pulse: assert property (@(posedge clock) disable iff (!reset_n)
        master_offset_check_done && master_offset_check_mv > OFS_FAIL_MV
        && !q.fail.master_offset_check |=> alarm && report)
        else $error("offset pulse missing");
    a_set_fail: assert property (@(posedge clock) disable iff (!reset_n)
        set_done && set_differ |=> prot_disable && ctrl_disable && alarm)
        else $error("settings failure not acted on");
    a_p15_prot: assert property (@(posedge clock) disable iff (!reset_n)
        fail_flags == 8'h04 |-> prot_disable && !ctrl_disable)
        else $error("15 V failure actions wrong");
    a_chan_warn: assert property (@(posedge clock) disable iff (!reset_n)
        fail_flags == 8'h00 && q.pulse_cnt == '0 |-> !alarm && !prot_disable)
        else $error("warning raised alarm");
    a_ram_fail: assert property (@(posedge clock) disable iff (!reset_n)
        ram_done && ram_bad |=> fail_flags[7] && bad_socket == $past(ram_socket))
        else $error("ram failure not acted on");
    a_new_settings: assert property (@(posedge clock) disable iff (!reset_n)
        settings_new |=> run_tests) else $error("tests not run");
    a_ground_pick: assert property (@(posedge clock) disable iff (!reset_n)
        run_tests |-> master_offset_check_ground)
        else $error("grounded input not selected");

    // A new failure of either offset test must restart the full alarm pulse, even
    // while an earlier pulse is still running.
    sequence s_new_pulse_fail;
        (master_offset_check_done && (master_offset_check_mv > OFS_FAIL_MV)
            && !q.fail.master_offset_check)
        || (chan_done && (chan_mv > OFS_FAIL_MV) && !q.fail.chan);
    endsequence
    sequence s_pulse_restarted;
        (q.pulse_cnt == CNT_W'(PULSE_CYCLES)) && alarm;
    endsequence
    a_pulse_retrigger: assert property (@(posedge clock) disable iff (!reset_n)
        s_new_pulse_fail |=> s_pulse_restarted)
        else $error("alarm pulse not restarted");
endmodule : sts_supervisor
`default_nettype wire

// >>> tb_self_test_supervisor.sv
// Self-checking bench for the self-test supervisor.
// Assumes short counts: pulse 20, second 10, retest 2 s, conversion 8.
`timescale 1ns/100ps
`default_nettype none
module tb_self_test_supervisor;
    import sts_pkg::*;
    localparam int PC = 20;
    localparam int CL = 8;
    localparam int SC = 10;
    localparam int RS = 2;
    logic clock, reset_n, settings_new, rom_done, ram_done, ram_bad, adc_start, adc_end;
    logic master_offset_check_done, chan_done, set_done, set_differ, sup_done;
    logic run_tests, master_offset_check_ground, prot_disable, ctrl_disable, alarm, report;
    logic [15:0] rom_sum, rom_stored;
    logic [3:0] rom_socket, ram_socket, bad_socket;
    logic [11:0] master_offset_check_mv, chan_mv, p5_mv, p15_mv;
    logic [7:0] fail_flags, warn_flags;
    int miscompares, n_tests, n_rep, plen, n_rep_exp, gap;
    int unsigned seed = 38;
    bit [7:0] ef, ew;
    bit [3:0] es;
    int ov[6] = '{50, 51, 75, 76, 80, 0};
    int v5[6] = '{300, 301, 400, 401, 0, 0};
    int v15[6] = '{800, 801, 1200, 0, 1201, 0};
    int tl[7] = '{0, 1, 2, 5, 6, 7, 8};
    sts_supervisor #(.PULSE_CYCLES(PC), .SEC_CYCLES(SC), .RETEST_SECS(RS), .CONV_LIMIT(CL)) dut (
        .clock, .reset_n, .settings_new, .rom_done, .rom_sum, .rom_stored, .rom_socket,
        .ram_done, .ram_bad, .ram_socket, .adc_start, .adc_end,
        .master_offset_check_done, .master_offset_check_mv,
        .chan_done, .chan_mv, .set_done, .set_differ, .sup_done, .p5_mv, .p15_mv,
        .run_tests, .master_offset_check_ground, .prot_disable, .ctrl_disable, .alarm,
        .report, .fail_flags, .warn_flags, .bad_socket);
    sts_partner far_end (.clock, .reset_n, .alarm, .report, .n_reports(n_rep), .pulse_len(plen));
    function automatic int unsigned rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic bit [1:0] lvl(int v, int w, int f);
        return {v > f, v > w && v <= f};
    endfunction : lvl
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d reports %0d", n_tests, miscompares, n_rep);
        if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    task automatic res(int t, logic [15:0] a, logic [15:0] b, logic [3:0] s);
        bit [7:0] of, ow;
        bit nf;
        of = ef;
        ow = ew;
        @(posedge clock);
        case (t)
            0: begin
                master_offset_check_mv <= a[11:0];
                master_offset_check_done <= 1'b1;
                {ef[0], ew[0]} = lvl(a, OFS_WARN_MV, OFS_FAIL_MV);
            end
            1: begin
                chan_mv <= a[11:0];
                chan_done <= 1'b1;
                {ef[1], ew[1]} = lvl(a, OFS_WARN_MV, OFS_FAIL_MV);
            end
            2: begin
                p5_mv <= a[11:0];
                p15_mv <= b[11:0];
                sup_done <= 1'b1;
                {ef[3], ew[3]} = lvl(a, P5_WARN_MV, P5_FAIL_MV);
                {ef[2], ew[2]} = lvl(b, P15_WARN_MV, P15_FAIL_MV);
            end
            5: begin
                set_differ <= b[0];
                set_done <= 1'b1;
                ef[5] = b[0];
            end
            default: ;
        endcase
        if (t == 6 || t == 8) begin
            rom_sum <= a;
            rom_stored <= b;
            rom_socket <= s;
            rom_done <= 1'b1;
            ef[6] = a != b;
            if (a != b) es = s;
        end
        if (t >= 7) begin
            ram_bad <= b[0];
            ram_socket <= ~s;
            ram_done <= 1'b1;
            ef[7] = b[0];
            if (b[0]) es = ~s;
        end
        nf = (ef[0] & ~of[0]) | (ef[1] & ~of[1]);
        if ((ef != of) || (ew != ow)) n_rep_exp++;
        @(posedge clock);
        {master_offset_check_done, chan_done, sup_done, set_done, rom_done, ram_done} <= '0;
        #1;
        chk("fail_flags", ef, fail_flags);
        chk("warn_flags", ew, warn_flags);
        chk("prot_disable", |ef[7:2], prot_disable);
        chk("ctrl_disable", ef[7] | ef[6] | ef[5] | ef[3], ctrl_disable);
        chk("alarm", |ef[7:2] | nf, alarm);
        chk("report", (ef != of) || (ew != ow), report);
        chk("bad_socket", es, bad_socket);
        repeat (PC + 4) @(posedge clock);
        #1 chk("alarm_held", |ef[7:2], alarm);
    endtask : res
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        end_of_test();
    end
    initial begin
        {reset_n, settings_new, rom_done, ram_done, ram_bad, adc_start, adc_end} = '0;
        {master_offset_check_done, chan_done, set_done, set_differ, sup_done} = '0;
        {rom_sum, rom_stored, rom_socket, ram_socket} = '0;
        {master_offset_check_mv, chan_mv, p5_mv, p15_mv} = '0;
        repeat (20) @(posedge clock);
        chk("run_in_reset", 1, run_tests);
        chk("alarm_in_reset", 0, alarm);
        reset_n <= 1'b1;
        @(posedge clock);
        #1 chk("run_after_reset", 0, run_tests);
        chk("ground_pick", 1, master_offset_check_ground);
        @(posedge clock);
        settings_new <= 1'b1;
        @(posedge clock);
        settings_new <= 1'b0;
        #1 chk("run_on_settings", 1, run_tests);
        @(posedge clock);
        #1 chk("run_one_cycle", 0, run_tests);
        for (int k = 0; k < 30 && run_tests !== 1'b1; k++) @(posedge clock) #1;
        chk("periodic_run", 1, run_tests);
        gap = 0;
        do begin
            @(posedge clock) #1;
            gap++;
        end while (run_tests !== 1'b1 && gap < 4 * SC * RS);
        chk("retest_gap", SC * RS, gap);
        $display("test start-up done");
        res(0, 80, 0, 0);
        chk("pulse_len", PC, plen);
        foreach (ov[i]) for (int t = 0; t < 2; t++) res(t, ov[i], 0, 0);
        foreach (v5[i]) res(2, v5[i], v15[i], 0);
        $display("test limits done");
        @(posedge clock);
        adc_start <= 1'b1;
        @(posedge clock);
        adc_start <= 1'b0;
        repeat (CL - 1) @(posedge clock);
        #1 chk("adc_early", 0, fail_flags[4]);
        repeat (4) @(posedge clock);
        #1 chk("adc_hang", 1, fail_flags[4]);
        chk("adc_prot", 1, prot_disable);
        chk("adc_ctrl", 0, ctrl_disable);
        chk("adc_alarm", 1, alarm);
        @(posedge clock);
        adc_start <= 1'b1;
        @(posedge clock);
        adc_start <= 1'b0;
        adc_end <= 1'b1;
        @(posedge clock);
        adc_end <= 1'b0;
        repeat (2) @(posedge clock);
        #1 chk("adc_clear", 0, fail_flags[4]);
        n_rep_exp += 2;
        $display("test converter done");
        res(8, 16'h1234, 16'h1235, 4'h5);
        for (int n = 0; n < 40; n++) res(tl[rnd() % 7], rnd() % 1500, (rnd() % 2) ? 0 : rnd() % 1500, rnd());
        $display("test random done");
        chk("report_count", n_rep_exp, n_rep);
        end_of_test();
    end
endmodule : tb_self_test_supervisor
`default_nettype wire
